// *** verilog/gpi_cfg.svh ***
`ifndef GPI_CFG_SVH
`define GPI_CFG_SVH
// ****************************************************************
// Register offsets, field positions, codes and reset values.
// ****************************************************************
`define GPI_OFF_CTRL      8'h00
`define GPI_OFF_STATUS    8'h04
`define GPI_OFF_APER_BASE 8'h08
`define GPI_OFF_APER_LIM  8'h0c
`define GPI_OFF_TLB_IDX   8'h10
`define GPI_OFF_TLB_TAG   8'h14
`define GPI_OFF_TLB_PHYS  8'h18
`define GPI_CTRL_EN       0
`define GPI_CTRL_MECH     1
`define GPI_CTRL_RATE     2
`define GPI_CTRL_LV       4
`define GPI_CTRL_RATIO    5
`define GPI_ST_NCNT       0
`define GPI_ST_FLAGS      8
`define GPI_ST_HCNT       16
`define GPI_TLB_VALID     0
`define GPI_PAGE_LSB      12
`define GPI_RATE_1X       2'h0
`define GPI_RATE_2X       2'h1
`define GPI_RATE_4X       2'h2
`define GPI_RATIO_1_1     2'h0
`define GPI_RATIO_2_3     2'h1
`define GPI_RATIO_1_2     2'h2
`define GPI_CMD_HI        0
`define GPI_CMD_WR        2
`define GPI_CMD_FW        3
`define GPI_SBA_IDLE      8'hff
`define GPI_SBA_LAST      2'h3
`define GPI_CTRL_RST      7'h00
`define GPI_APER_RST      20'h00000
`endif

// *** verilog/gpi_pkg.sv ***
// ****************************************************************
// Types shared by the graphics port interface.
// ****************************************************************
package gpi_pkg;
   typedef struct packed {
      logic        clk;
      logic        pipe_n;
      logic        req_n;
      logic [2:0]  stb;
      logic [2:0]  stb_n;
      logic [7:0]  sba;
      logic [31:0] ad;
      logic [3:0]  cbe_n;
   } gpi_pins_t;
   typedef struct packed {
      logic       en;
      logic       mech;
      logic [1:0] rate;
      logic       lv;
      logic [1:0] ratio;
   } gpi_ctrl_t;
   typedef struct packed {
      logic stb_fault;
      logic hub_ref;
      logic fw_ref;
      logic tlb_miss;
      logic ovf;
   } gpi_stat_t;
   typedef struct packed {
      logic        valid;
      logic [19:0] tag;
      logic [19:0] phys;
   } gpi_tlb_t;
   typedef struct packed {
      logic [3:0]  cmd;
      logic [31:0] addr;
   } gpi_req_t;
   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic        hi;
      logic        aper;
      logic        tlb_miss;
      logic        snoop_cwb;
      logic        snoop_awq;
      logic        snoop_host;
   } gpi_mreq_t;
endpackage

// *** verilog/gpi_port.sv ***
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "gpi_cfg.svh"
// How it works
// - One connector; no lock or error pins.
// - Quad rate needs low voltage, differential strobes.
// - Double rate allowed at either voltage.
// - Fast writes refused at quad rate.
// - Graphics cycles never snoop the host bus.
// - Pipelined or sideband requests, never both.
// - Request queue holds thirty-two requests.
// - High-priority requests served before normal ones.
// - Aperture hits translate through twenty-entry buffer.
// - Hub traffic limited to hub memory writes.
// - Cacheable reads check the cacheable write buffer.
// - Aperture reads check the aperture write queue.
// - Frame-based aperture traffic needs no snoop.
// - Synchronous clock ratios 1:1, 2:3, 1:2.
// - Quad rate: four samples per port clock.
// - Double rate: two samples, single strobes.
// - Single rate: sample on port clock rise.
// - Each data group has its own strobe.
// - Complement strobes used only at quad rate.
// - Control pins always sampled on clock rise.
module gpi_port
   import gpi_pkg::*;
#(
   parameter int QD    = 32,
   parameter int HD    = 4,
   parameter int TLB_N = 20
) (
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   input  wire logic        port_clk_in,
   input  wire logic        pipe_n_in,
   input  wire logic        req_n_in,
   input  wire logic [31:0] ad_in,
   input  wire logic [3:0]  cbe_n_in,
   input  wire logic [1:0]  ad_stb_in,
   input  wire logic [1:0]  ad_stb_n_in,
   input  wire logic [7:0]  sba_in,
   input  wire logic        sb_stb_in,
   input  wire logic        sb_stb_n_in,
   output logic             gnt_n_out,
   output logic             stb_n_drive_out,
   output logic             sig_1v5_out,
   output logic      [1:0]  host_ratio_out,
   input  wire logic        hub_req_valid_in,
   input  wire logic        hub_req_write_in,
   input  wire logic [31:0] hub_req_addr_in,
   output logic             post_valid_out,
   output logic      [31:0] post_addr_out,
   output logic             mem_valid_out,
   output gpi_mreq_t        mem_req_out,
   input  wire logic        mem_ready_in
);
   localparam int QW = $clog2(QD);
   localparam int CW = $clog2(QD + 1);
   localparam int HW = $clog2(HD);
   localparam int HC = $clog2(HD + 1);
   localparam int IW = $clog2(TLB_N);

   typedef struct packed {
      gpi_pins_t               sync1;
      gpi_pins_t               sync2;
      gpi_pins_t               prev;
      gpi_ctrl_t               ctrl;
      gpi_stat_t               stat;
      logic [19:0]             aper_base;
      logic [19:0]             aper_lim;
      logic [IW-1:0]           tlb_idx;
      gpi_tlb_t [TLB_N-1:0]    tlb;
      logic [31:0]             ad_hold;
      logic [3:0]              cbe_hold;
      logic [31:0]             sba_word;
      logic [1:0]              sba_cnt;
      gpi_req_t [QD-1:0]       nq;
      logic [QW-1:0]           nhead;
      logic [QW-1:0]           ntail;
      logic [CW-1:0]           ncnt;
      gpi_req_t [HD-1:0]       hq;
      logic [HW-1:0]           hhead;
      logic [HW-1:0]           htail;
      logic [HC-1:0]           hcnt;
      logic                    mvalid;
      gpi_mreq_t               mreq;
      logic [31:0]             rdata;
      logic                    gnt_n;
      logic                    post_valid;
      logic [31:0]             post_addr;
      logic                    stbn_en;
   } gpi_state_t;

   gpi_state_t s;
   gpi_state_t next_s;
   logic       clk_rise;
   logic       push_v;
   gpi_req_t   push_req;
   logic       pop_take;
   logic [2:0] evt;
   gpi_mreq_t  xl;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Capture event of one strobe group at the configured rate.
   function automatic logic stb_edge(input logic [1:0] rate,
                                     input logic rise, cur, prv, cur_n);
      case (rate)
         `GPI_RATE_1X: stb_edge = rise;
         `GPI_RATE_2X: stb_edge = cur ^ prv;
         `GPI_RATE_4X: stb_edge = (cur ^ prv) & (cur_n != cur);
         default:      stb_edge = 1'b0;
      endcase
   endfunction

   // Page translation and snoop steering for one queued request.
   function automatic gpi_mreq_t xlate(input gpi_req_t r);
      gpi_mreq_t m;
      logic [19:0] pg;
      pg = r.addr[31:`GPI_PAGE_LSB];
      m.addr       = r.addr;
      m.write      = r.cmd[`GPI_CMD_WR];
      m.hi         = r.cmd[`GPI_CMD_HI];
      m.aper       = (pg >= s.aper_base) && (pg <= s.aper_lim);
      m.tlb_miss   = m.aper;
      for (int e = 0; e < TLB_N; e++) begin
         if (m.aper && s.tlb[e].valid && s.tlb[e].tag == pg) begin
            m.addr     = {s.tlb[e].phys, r.addr[`GPI_PAGE_LSB-1:0]};
            m.tlb_miss = 1'b0;
         end
      end
      // Frame-based aperture cycles bypass this path, so only queued
      // sideband and pipelined reads carry an aperture snoop.
      m.snoop_cwb  = !m.write && !m.aper;
      m.snoop_awq  = !m.write && m.aper;
      m.snoop_host = 1'b0;
      return m;
   endfunction

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // Pins cross in through two flip-flops; the second is decoded against a third, delayed copy.
   always_comb begin
      next_s = s;
      next_s.sync1.clk    = port_clk_in;
      next_s.sync1.pipe_n = pipe_n_in;
      next_s.sync1.req_n  = req_n_in;
      next_s.sync1.stb    = {sb_stb_in, ad_stb_in};
      next_s.sync1.stb_n  = {sb_stb_n_in, ad_stb_n_in};
      next_s.sync1.sba    = sba_in;
      next_s.sync1.ad     = ad_in;
      next_s.sync1.cbe_n  = cbe_n_in;
      next_s.sync2 = s.sync1;
      next_s.prev  = s.sync2;
      clk_rise = s.sync2.clk & ~s.prev.clk;
      push_v   = 1'b0;
      push_req = '0;
      pop_take = 1'b0;
      xl       = '0;

      // Register writes; flag clears come first so a set below wins.
      if (reg_wr_in) begin
         case (reg_addr_in)
            `GPI_OFF_CTRL: begin
               next_s.ctrl.en = reg_wdata_in[`GPI_CTRL_EN];
               if (!s.ctrl.en)
                  next_s.ctrl.mech = reg_wdata_in[`GPI_CTRL_MECH];
               if (reg_wdata_in[`GPI_CTRL_RATE +: 2] == `GPI_RATE_1X ||
                   reg_wdata_in[`GPI_CTRL_RATE +: 2] == `GPI_RATE_2X ||
                   (reg_wdata_in[`GPI_CTRL_RATE +: 2] == `GPI_RATE_4X &&
                    reg_wdata_in[`GPI_CTRL_LV])) begin
                  next_s.ctrl.rate = reg_wdata_in[`GPI_CTRL_RATE +: 2];
                  next_s.ctrl.lv   = reg_wdata_in[`GPI_CTRL_LV];
               end
               if (reg_wdata_in[`GPI_CTRL_RATIO +: 2] != 2'h3)
                  next_s.ctrl.ratio = reg_wdata_in[`GPI_CTRL_RATIO +: 2];
            end
            `GPI_OFF_STATUS:
               next_s.stat = s.stat &
                  ~gpi_stat_t'(reg_wdata_in[`GPI_ST_FLAGS +: 5]);
            `GPI_OFF_APER_BASE:
               next_s.aper_base = reg_wdata_in[31:`GPI_PAGE_LSB];
            `GPI_OFF_APER_LIM:
               next_s.aper_lim = reg_wdata_in[31:`GPI_PAGE_LSB];
            `GPI_OFF_TLB_IDX:
               if (reg_wdata_in[IW-1:0] < IW'(TLB_N))
                  next_s.tlb_idx = reg_wdata_in[IW-1:0];
            `GPI_OFF_TLB_TAG: begin
               next_s.tlb[s.tlb_idx].tag =
                  reg_wdata_in[31:`GPI_PAGE_LSB];
               next_s.tlb[s.tlb_idx].valid =
                  reg_wdata_in[`GPI_TLB_VALID];
            end
            `GPI_OFF_TLB_PHYS:
               next_s.tlb[s.tlb_idx].phys =
                  reg_wdata_in[31:`GPI_PAGE_LSB];
            default: ;
         endcase
      end

      // Read data stand for exactly one cycle; unmapped reads give zero.
      next_s.rdata = '0;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `GPI_OFF_CTRL: begin
               next_s.rdata[`GPI_CTRL_EN]       = s.ctrl.en;
               next_s.rdata[`GPI_CTRL_MECH]     = s.ctrl.mech;
               next_s.rdata[`GPI_CTRL_RATE +: 2] = s.ctrl.rate;
               next_s.rdata[`GPI_CTRL_LV]       = s.ctrl.lv;
               next_s.rdata[`GPI_CTRL_RATIO +: 2] = s.ctrl.ratio;
            end
            `GPI_OFF_STATUS: begin
               next_s.rdata[`GPI_ST_NCNT +: CW] = s.ncnt;
               next_s.rdata[`GPI_ST_FLAGS +: 5] = s.stat;
               next_s.rdata[`GPI_ST_HCNT +: HC] = s.hcnt;
            end
            `GPI_OFF_APER_BASE:
               next_s.rdata[31:`GPI_PAGE_LSB] = s.aper_base;
            `GPI_OFF_APER_LIM:
               next_s.rdata[31:`GPI_PAGE_LSB] = s.aper_lim;
            `GPI_OFF_TLB_IDX:
               next_s.rdata[IW-1:0] = s.tlb_idx;
            `GPI_OFF_TLB_TAG: begin
               next_s.rdata[31:`GPI_PAGE_LSB] = s.tlb[s.tlb_idx].tag;
               next_s.rdata[`GPI_TLB_VALID]   = s.tlb[s.tlb_idx].valid;
            end
            `GPI_OFF_TLB_PHYS:
               next_s.rdata[31:`GPI_PAGE_LSB] = s.tlb[s.tlb_idx].phys;
            default: ;
         endcase
      end

      // Each strobe group clocks its own lanes; a quad-rate edge whose
      // complement is not opposite is a fault and captures nothing.
      for (int g = 0; g < 3; g++) begin
         evt[g] = stb_edge(s.ctrl.rate, clk_rise, s.sync2.stb[g],
                           s.prev.stb[g], s.sync2.stb_n[g]);
         if (s.ctrl.rate == `GPI_RATE_4X &&
             (s.sync2.stb[g] ^ s.prev.stb[g]) &&
             s.sync2.stb_n[g] == s.sync2.stb[g])
            next_s.stat.stb_fault = 1'b1;
      end
      if (evt[0]) begin
         next_s.ad_hold[15:0] = s.sync2.ad[15:0];
         next_s.cbe_hold[1:0] = s.sync2.cbe_n[1:0];
      end
      if (evt[1]) begin
         next_s.ad_hold[31:16] = s.sync2.ad[31:16];
         next_s.cbe_hold[3:2]  = s.sync2.cbe_n[3:2];
      end

      // Control pins are taken on port clock rises in every mode.
      if (clk_rise) begin
         next_s.gnt_n = ~(s.ctrl.en & ~s.sync2.req_n &
                          (s.ncnt < CW'(QD)));
         if (s.ctrl.en && !s.ctrl.mech && !s.sync2.pipe_n) begin
            push_v = 1'b1;
            if (s.ctrl.rate == `GPI_RATE_1X)
               push_req = {~s.sync2.cbe_n, s.sync2.ad};
            else
               push_req = {~s.cbe_hold, s.ad_hold};
         end
      end
      // Sideband bytes gather four to a request; idle bytes are skipped.
      if (s.ctrl.en && s.ctrl.mech && evt[2] &&
          s.sync2.sba != `GPI_SBA_IDLE) begin
         next_s.sba_word = {s.sba_word[23:0], s.sync2.sba};
         next_s.sba_cnt  = s.sba_cnt + 2'h1;
         if (s.sba_cnt == `GPI_SBA_LAST) begin
            push_v   = 1'b1;
            push_req = {s.sync2.sba[3:0],
                        s.sba_word[23:0], s.sync2.sba};
            push_req.addr[3:0] = 4'h0;
         end
      end
      if (!s.ctrl.en)
         next_s.sba_cnt = 2'h0;

      // Memory side: high-priority requests drain first.
      if (!s.mvalid || mem_ready_in) begin
         next_s.mvalid = 1'b0;
         if (s.hcnt != '0) begin
            pop_take = 1'b1;
            xl = xlate(s.hq[s.hhead]);
            next_s.hhead = s.hhead + HW'(1);
            next_s.hcnt  = s.hcnt - HC'(1);
         end else if (s.ncnt != '0) begin
            pop_take = 1'b1;
            xl = xlate(s.nq[s.nhead]);
            next_s.nhead = s.nhead + QW'(1);
            next_s.ncnt  = s.ncnt - CW'(1);
         end
         if (pop_take) begin
            next_s.mvalid = 1'b1;
            next_s.mreq   = xl;
            if (xl.tlb_miss)
               next_s.stat.tlb_miss = 1'b1;
         end
      end

      // Enqueue; a full queue drops the request and flags overflow.
      if (push_v) begin
         if (push_req.cmd[`GPI_CMD_FW] && s.ctrl.rate == `GPI_RATE_4X)
            next_s.stat.fw_ref = 1'b1;
         else if (push_req.cmd[`GPI_CMD_HI]) begin
            if (s.hcnt == HC'(HD))
               next_s.stat.ovf = 1'b1;
            else begin
               next_s.hq[s.htail] = push_req;
               next_s.htail = s.htail + HW'(1);
               next_s.hcnt  = next_s.hcnt + HC'(1);
            end
         end else if (s.ncnt == CW'(QD))
            next_s.stat.ovf = 1'b1;
         else begin
            next_s.nq[s.ntail] = push_req;
            next_s.ntail = s.ntail + QW'(1);
            next_s.ncnt  = next_s.ncnt + CW'(1);
         end
      end

      // Only hub-originated memory writes pass to the port.
      next_s.post_valid = hub_req_valid_in & hub_req_write_in;
      if (hub_req_valid_in && hub_req_write_in)
         next_s.post_addr = hub_req_addr_in;
      if (hub_req_valid_in && !hub_req_write_in)
         next_s.stat.hub_ref = 1'b1;
      next_s.stbn_en = (next_s.ctrl.rate == `GPI_RATE_4X);
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Queue pointers wrap by overflow, so depths must be powers of two.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s           <= '0;
         s.ctrl      <= `GPI_CTRL_RST;
         s.aper_base <= `GPI_APER_RST;
         s.aper_lim  <= `GPI_APER_RST;
         s.gnt_n     <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_out   = s.rdata;
   assign gnt_n_out       = s.gnt_n;
   assign stb_n_drive_out = s.stbn_en;
   assign sig_1v5_out     = s.ctrl.lv;
   assign host_ratio_out  = s.ctrl.ratio;
   assign post_valid_out  = s.post_valid;
   assign post_addr_out   = s.post_addr;
   assign mem_valid_out   = s.mvalid;
   assign mem_req_out     = s.mreq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   property p_no_host_snoop;
      s.mvalid |-> !s.mreq.snoop_host;
   endproperty
   a_no_host_snoop: assert property (p_no_host_snoop)
      else $error("Host snoop requested.");
   property p_fw_refused;
      push_v && push_req.cmd[`GPI_CMD_FW] && s.ctrl.rate == `GPI_RATE_4X
         |=> s.stat.fw_ref && s.htail == $past(s.htail);
   endproperty
   a_fw_refused: assert property (p_fw_refused)
      else $error("Fast write accepted at quad rate.");
   property p_rate4_lv;
      s.ctrl.rate == `GPI_RATE_4X |-> s.ctrl.lv;
   endproperty
   a_rate4_lv: assert property (p_rate4_lv)
      else $error("Quad rate without low voltage.");
   property p_mech_locked;
      s.ctrl.en && $past(s.ctrl.en) |-> $stable(s.ctrl.mech);
   endproperty
   a_mech_locked: assert property (p_mech_locked)
      else $error("Mechanism changed while enabled.");
   property p_queue_bound;
      s.ncnt == CW'(QD) && push_v && !push_req.cmd[`GPI_CMD_HI]
         && !push_req.cmd[`GPI_CMD_FW] |=> s.stat.ovf;
   endproperty
   a_queue_bound: assert property (p_queue_bound)
      else $error("Overflow not flagged.");
   property p_hi_first;
      pop_take && s.hcnt != '0 |=> s.mvalid && s.mreq.hi;
   endproperty
   a_hi_first: assert property (p_hi_first)
      else $error("Normal request passed a high one.");
   property p_ap_snoop;
      s.mvalid && s.mreq.aper && !s.mreq.write
         |-> s.mreq.snoop_awq && !s.mreq.snoop_cwb;
   endproperty
   a_ap_snoop: assert property (p_ap_snoop)
      else $error("Aperture read misses queue check.");
   property p_cache_snoop;
      s.mvalid && !s.mreq.aper && !s.mreq.write |-> s.mreq.snoop_cwb;
   endproperty
   a_cache_snoop: assert property (p_cache_snoop)
      else $error("Cacheable read misses buffer check.");
   property p_hub_read;
      hub_req_valid_in && !hub_req_write_in
         |=> s.stat.hub_ref && !s.post_valid;
   endproperty
   a_hub_read: assert property (p_hub_read)
      else $error("Hub read passed to the port.");
   property p_ratio;
      s.ctrl.ratio != 2'h3;
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("Unsupported clock ratio.");
endmodule

// *** sim/gpi_card.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Behavioural graphics card on the far side of the port.
// ****************************************************************
module gpi_card (
   input  wire logic        clk_in,
   output logic             pclk_out,
   output logic             pipe_n_out,
   output logic             req_n_out,
   output logic      [31:0] ad_out,
   output logic      [3:0]  cbe_n_out,
   output logic      [1:0]  stb_out,
   output logic      [1:0]  stb_n_out,
   output logic      [7:0]  sba_out
);
   // The link clock stands low between frames; control, command, sideband and complement strobe lines idle high, data and strobes low.
   initial begin
      pclk_out = 1'b0;
      pipe_n_out = 1'b1;
      req_n_out = 1'b1;
      ad_out = 32'h0;
      cbe_n_out = 4'hf;
      stb_out = 2'h0;
      stb_n_out = 2'h3;
      sba_out = 8'hff;
   end
   // One 200 ns port clock period; values only change while it is low.
   task automatic tick();
      repeat (4) @(posedge clk_in);
      pclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      pclk_out <= 1'b0;
   endtask
   // Pipelined request; each lane strobe toggles against its complement.
   task automatic pipe(input logic [3:0] cmd, input logic [31:0] addr);
      @(posedge clk_in);
      pipe_n_out <= 1'b0;
      req_n_out <= 1'b0;
      ad_out <= addr;
      cbe_n_out <= ~cmd;
      @(posedge clk_in);
      stb_out <= ~stb_out;
      stb_n_out <= ~stb_n_out;
      tick();
      pipe_n_out <= 1'b1;
      req_n_out <= 1'b1;
      ad_out <= ~addr; // Released lanes must not keep showing stale data.
      cbe_n_out <= cmd;
   endtask
   // Sideband word, most significant byte first.
   task automatic side(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         sba_out <= w[31-8*i -: 8];
         tick();
      end
      sba_out <= 8'hff;
   endtask
endmodule

// *** sim/gpi_port_tb.sv ***
`timescale 1ns/1ps
`include "gpi_cfg.svh"
// ****************************************************************
// Self-checking bench for the graphics port.
// ****************************************************************
module gpi_port_tb;
   import gpi_pkg::*;
   logic        clk, rst, wr, rd, hv, hw, rdy, rd_d, pclk, pipe_n, req_n;
   logic        gnt, drv, lv, mv, pv;
   logic [1:0]  ratio, stb, stb_n;
   logic [3:0]  cbe_n;
   logic [7:0]  addr, sba;
   logic [31:0] wdata, rdata, ha, pa, ad, rs;
   gpi_mreq_t   mreq;
   gpi_mreq_t   exp_m[$];
   logic [31:0] exp_r[$];
   logic [31:0] exp_p[$];
   int          n_fail, check_count, cycles;
   gpi_card i_card (.clk_in(clk), .pclk_out(pclk), .pipe_n_out(pipe_n),
      .req_n_out(req_n), .ad_out(ad), .cbe_n_out(cbe_n), .stb_out(stb),
      .stb_n_out(stb_n), .sba_out(sba));
   gpi_port i_dut (.clk_sys_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .port_clk_in(pclk), .pipe_n_in(pipe_n),
      .req_n_in(req_n), .ad_in(ad), .cbe_n_in(cbe_n), .ad_stb_in(stb),
      .ad_stb_n_in(stb_n), .sba_in(sba), .sb_stb_in(1'b0),
      .sb_stb_n_in(1'b1), .gnt_n_out(gnt), .stb_n_drive_out(drv),
      .sig_1v5_out(lv), .host_ratio_out(ratio), .hub_req_valid_in(hv),
      .hub_req_write_in(hw), .hub_req_addr_in(ha), .post_valid_out(pv),
      .post_addr_out(pa), .mem_valid_out(mv), .mem_req_out(mreq),
      .mem_ready_in(rdy));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   function automatic gpi_mreq_t mr(logic [31:0] a, logic w, h, ap, c, q);
      return '{a, w, h, ap, 1'b0, c, q, 1'b0};
   endfunction
   task automatic chk(input string n, input logic [63:0] e, s);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      exp_r.push_back(e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic hub(input logic w, input logic [31:0] a);
      @(posedge clk);
      hv <= 1'b1;
      hw <= w;
      ha <= a;
      @(posedge clk);
      hv <= 1'b0;
   endtask
   // Bounded wait: memory stalls at random, so the drain time varies.
   task automatic drain();
      for (int i = 0; i < 400 && exp_m.size() != 0; i++)
         @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Monitor: random memory stalls, oldest-note compares and a hang limit.
   always @(posedge clk) begin
      rdy <= xs() >> 31;
      if (rd_d)
         chk("rdata", exp_r.pop_front(), rdata);
      rd_d = rd;
      if (mv && rdy)
         chk("mem_req", exp_m.pop_front(), mreq);
      if (pv)
         chk("post_addr", exp_p.pop_front(), pa);
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         complete_run();
      end
   end
   // Main sequence.
   initial begin
      {rst, rs} = {1'b1, 32'd23};
      {wr, rd, hv, hw, addr, wdata, ha} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rreg(`GPI_OFF_CTRL, 32'h0);
      rreg(8'h40, 32'h0);
      wreg(`GPI_OFF_CTRL, 32'h08);
      rreg(`GPI_OFF_CTRL, 32'h0);
      wreg(`GPI_OFF_CTRL, 32'h04);
      rreg(`GPI_OFF_CTRL, 32'h04);
      wreg(`GPI_OFF_CTRL, 32'h18);
      repeat (2) @(posedge clk);
      chk("stb_n_drive", 3, {drv, lv});
      for (int r = 0; r < 4; r++) begin
         wreg(`GPI_OFF_CTRL, 32'(r % 4) << 5);
         repeat (2) @(posedge clk);
         chk("host_ratio", (r == 3) ? 2 : r, ratio);
      end
      wreg(`GPI_OFF_APER_BASE, 32'h1000_0000);
      wreg(`GPI_OFF_APER_LIM, 32'h1000_0000);
      wreg(`GPI_OFF_TLB_IDX, 32'h0);
      wreg(`GPI_OFF_TLB_PHYS, 32'h2345_6000);
      wreg(`GPI_OFF_TLB_TAG, 32'h1000_0001);
      wreg(`GPI_OFF_CTRL, 32'h01);
      exp_m.push_back(mr(32'h1230, 0, 0, 0, 1, 0));
      i_card.pipe(4'h0, 32'h1230);
      chk("gnt_n", 0, gnt);
      exp_m.push_back(mr(32'h2345_6abc, 0, 0, 1, 0, 1));
      i_card.pipe(4'h0, 32'h1000_0abc);
      exp_m.push_back(mr(32'h2000, 1, 0, 0, 0, 0));
      i_card.pipe(4'h4, 32'h2000);
      drain();
      exp_m.push_back(mr(32'h3000, 0, 1, 0, 1, 0));
      i_card.pipe(4'h1, 32'h3000);
      drain();
      wreg(`GPI_OFF_CTRL, 32'h19);
      i_card.pipe(4'h8, 32'h4000);
      rreg(`GPI_OFF_STATUS, 32'h400);
      wreg(`GPI_OFF_STATUS, 32'h400);
      rreg(`GPI_OFF_STATUS, 32'h0);
      exp_p.push_back(32'h5000);
      hub(1'b1, 32'h5000);
      hub(1'b0, 32'h6000);
      rreg(`GPI_OFF_STATUS, 32'h800);
      wreg(`GPI_OFF_CTRL, 32'h0);
      wreg(`GPI_OFF_CTRL, 32'h03);
      wreg(`GPI_OFF_CTRL, 32'h01);
      rreg(`GPI_OFF_CTRL, 32'h03);
      exp_m.push_back(mr(32'h1234_5670, 0, 1, 0, 1, 0));
      i_card.side(32'h1234_5671);
      i_card.pipe(4'h0, 32'h7000);
      drain();
      repeat (20) @(posedge clk);
      chk("pending", 0, exp_m.size() + exp_p.size());
      complete_run();
   end
endmodule
